// *** hybrid_trip_map.vh ***
// constants for the hybrid pilot / open-pole trip block
// assumes a 125 MHz clock; times stay in ms here, MS_CYCLES gives the cycles per ms
`ifndef HYBRID_TRIP_MAP_VH
`define HYBRID_TRIP_MAP_VH

`define CLOCK_MHZ          125
`define MS_US              1000
`define MS_CYCLES          (`CLOCK_MHZ * `MS_US)

`define ECHO_WIN_MS        8'h50
`define ECHO_WIN_3T_MS     8'h32
`define TB_DROP_MS         8'h1E
`define TB_DROP_3T_MS      8'h3C
`define RCV_COUNT_3T       2'h2

`define ADDR_W             4
`define REG_CTRL           4'h0
`define REG_WI_DELAY       4'h4
`define REG_STATUS         4'h8

`define CTRL_RST           8'h17
`define WI_DELAY_RST       8'h08
`define CTRL_SPT_BIT       0
`define CTRL_WI_BIT        1
`define CTRL_SCHEME_LSB    2
`define CTRL_RCV_LSB       4
`define SCHEME_POTT        2'h0
`define SCHEME_HYBRID      2'h1

`endif

// *** ms_timer.v ***
// millisecond pickup timer: counts ticks while run is high
// assumes tick is a one-cycle pulse once per millisecond, same clock
`timescale 1ns/1ps
module ms_timer #(
    parameter W = 8
) (
    input  wire         clock,
    input  wire         rst,
    input  wire         tick,
    input  wire         run,
    input  wire [W-1:0] limit,
    output wire         expired
);
    reg  [W:0] cnt_r;
    wire [W:0] last;

    // one tick past the limit: the first tick may come at once after start,
    // so the delay is never short of the limit and at most one ms over it
    assign last = {1'b0, limit} + {{W{1'b0}}, 1'b1};

    // restart from zero whenever the input drops before expiry
    always @(posedge clock) begin
        if (rst || !run) begin
            cnt_r <= {(W+1){1'b0}};
        end else if (tick && cnt_r != last) begin
            cnt_r <= cnt_r + {{W{1'b0}}, 1'b1};
        end
    end

    assign expired = run && (cnt_r == last);
endmodule

// *** hybrid_trip_logic.v ***
// hybrid pilot trip logic: echo keying, weak-infeed trip, phase selection,
// open-pole handling and reclose initiation
// assumes relay element inputs arrive asynchronously and settings come
// over a simple strobe register port on the same clock
`timescale 1ns/1ps
`include "hybrid_trip_map.vh"
module hybrid_trip_logic #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input  wire                clock,
    input  wire                rst,
    input  wire [`ADDR_W-1:0]  addr,
    input  wire [31:0]         wdata,
    input  wire                wr,
    input  wire                rd,
    output reg  [31:0]         rdata_r,
    input  wire                rx_trip,
    input  wire                blocking_op,
    input  wire                overreach_op,
    input  wire                zone1_op,
    input  wire                fd_magnitude,
    input  wire                fd_change,
    input  wire                v1_ok,
    input  wire [2:0]          phase_sel,
    input  wire                multiphase,
    input  wire [2:0]          undervoltage,
    input  wire [2:0]          pole_open,
    input  wire                reclose_cancel,
    output reg                 tx_key_r,
    output reg  [2:0]          trip_r,
    output reg                 weak_infeed_trip_r,
    output reg                 echo_gate_r,
    output reg                 transient_block_r,
    output reg                 reclose_initiate_single_r,
    output reg                 reclose_initiate_three_r,
    output reg                 pole_any_open_r,
    output reg                 pole_one_open_r,
    output reg                 pole_all_open_r,
    output reg                 single_phase_trip_flag_r,
    output reg                 open_pole_flag_r,
    output reg  [2:0]          phase_pair_enable_r,
    output reg  [2:0]          ground_dist_enable_r,
    output reg                 fd_magnitude_enable_r,
    output reg                 ground_directional_enable_r,
    output reg                 ground_inst_backup_enable_r,
    output reg                 ground_time_backup_enable_r
);
    localparam NIN = 18;

    // two-flop synchroniser for every relay input
    wire [NIN-1:0] raw_in;
    reg  [NIN-1:0] meta_r;
    reg  [NIN-1:0] sync_r;

    assign raw_in = {rx_trip, blocking_op, overreach_op, zone1_op,
                     fd_magnitude, fd_change, v1_ok, phase_sel,
                     multiphase, undervoltage, pole_open, reclose_cancel};

    always @(posedge clock) begin
        if (rst) begin
            meta_r <= {NIN{1'b0}};
            sync_r <= {NIN{1'b0}};
        end else begin
            meta_r <= raw_in;
            sync_r <= meta_r;
        end
    end

    wire       rx_s       = sync_r[17];
    wire       blk_s      = sync_r[16];
    wire       ovr_s      = sync_r[15];
    wire       z1_s       = sync_r[14];
    wire       fdmag_s    = sync_r[13];
    wire       fdchg_s    = sync_r[12];
    wire       v1ok_s     = sync_r[11];
    wire [2:0] psel_s     = sync_r[10:8];
    wire       multi_s    = sync_r[7];
    wire [2:0] uv_s       = sync_r[6:4];
    wire [2:0] pole_s     = sync_r[3:1];
    wire       cancel_s   = sync_r[0];

    // settings registers
    reg [7:0] ctrl_r;
    reg [7:0] wi_delay_r;

    wire       spt_en     = ctrl_r[`CTRL_SPT_BIT];
    wire       wi_en      = ctrl_r[`CTRL_WI_BIT];
    wire [1:0] scheme_sel = ctrl_r[`CTRL_SCHEME_LSB+1:`CTRL_SCHEME_LSB];
    wire [1:0] rcv_count  = ctrl_r[`CTRL_RCV_LSB+1:`CTRL_RCV_LSB];
    wire       hybrid     = (scheme_sel == `SCHEME_HYBRID);

    always @(posedge clock) begin
        if (rst) begin
            ctrl_r     <= `CTRL_RST;
            wi_delay_r <= `WI_DELAY_RST;
        end else if (wr) begin
            if (addr == `REG_CTRL) begin
                ctrl_r <= wdata[7:0];
            end
            if (addr == `REG_WI_DELAY) begin
                wi_delay_r <= wdata[7:0];
            end
        end
    end

    wire [31:0] status_word;

    assign status_word = {15'h0000,
                          ground_dist_enable_r, phase_pair_enable_r,
                          transient_block_r, echo_gate_r,
                          pole_all_open_r, pole_one_open_r, pole_any_open_r,
                          open_pole_flag_r, single_phase_trip_flag_r,
                          trip_r, tx_key_r};

    // read data stand only in the cycle after the strobe; unmapped reads zero
    always @(posedge clock) begin
        if (rst || !rd) begin
            rdata_r <= 32'h00000000;
        end else begin
            case (addr)
                `REG_CTRL:     rdata_r <= {24'h000000, ctrl_r};
                `REG_WI_DELAY: rdata_r <= {24'h000000, wi_delay_r};
                `REG_STATUS:   rdata_r <= status_word;
                default:       rdata_r <= 32'h00000000;
            endcase
        end
    end

    // millisecond tick shared by all timers
    localparam CW = 17;
    localparam [31:0]   MS_LAST_FULL = MS_CYCLES - 1;
    localparam [CW-1:0] MS_LAST      = MS_LAST_FULL[CW-1:0];
    reg [CW-1:0] ms_cnt_r;
    reg          ms_tick_r;

    always @(posedge clock) begin
        if (rst) begin
            ms_cnt_r  <= {CW{1'b0}};
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == MS_LAST) begin
            ms_cnt_r  <= {CW{1'b0}};
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r  <= ms_cnt_r + 1'b1;
            ms_tick_r <= 1'b0;
        end
    end

    // three-terminal timing adjusts itself from the settings
    wire       three_term = hybrid && (rcv_count == `RCV_COUNT_3T);
    wire [7:0] echo_win_ms = three_term ? `ECHO_WIN_3T_MS : `ECHO_WIN_MS;
    wire [7:0] tb_drop_ms  = three_term ? `TB_DROP_3T_MS : `TB_DROP_MS;

    // fault detector: magnitude terms ignored while a pole is open, since
    // an open pole leaves a steady negative and zero sequence current
    wire fault_det = fdchg_s | (fdmag_s & ~open_pole_flag_r);

    // transient block: extended dropout after reverse blocking resets
    reg  tb_hold_r;
    wire tb_expired;

    ms_timer #(.W(8)) transient_block_dropout_timer (
        .clock   (clock),
        .rst     (rst),
        .tick    (ms_tick_r),
        .run     (tb_hold_r & ~blk_s),
        .limit   (tb_drop_ms),
        .expired (tb_expired)
    );

    always @(posedge clock) begin
        if (rst) begin
            tb_hold_r <= 1'b0;
        end else if (blk_s) begin
            tb_hold_r <= 1'b1;
        end else if (tb_expired) begin
            tb_hold_r <= 1'b0;
        end
    end

    wire tb_active = blk_s | tb_hold_r;

    // echo path
    wire receive_merge_gate = rx_s & ~blk_s & hybrid;
    wire echo_expired;

    ms_timer #(.W(8)) echo_window_timer (
        .clock   (clock),
        .rst     (rst),
        .tick    (ms_tick_r),
        .run     (receive_merge_gate),
        .limit   (echo_win_ms),
        .expired (echo_expired)
    );

    wire echo_gate = receive_merge_gate & ~echo_expired;

    // weak-infeed trip
    wire fault_or_undervoltage_gate = fault_det | ~v1ok_s;
    wire weak_infeed_gate = wi_en & ~blk_s & fault_or_undervoltage_gate
                            & receive_merge_gate & ~echo_expired;
    wire wi_expired;

    ms_timer #(.W(8)) weak_infeed_trip_timer (
        .clock   (clock),
        .rst     (rst),
        .tick    (ms_tick_r),
        .run     (weak_infeed_gate),
        .limit   (wi_delay_r),
        .expired (wi_expired)
    );

    // spurious receiver bursts shorter than the pickup never trip
    wire wi_trip = wi_expired & fault_det;

    // transmitter keying: own overreach or echo, never while blocking
    wire key_merge_gate   = ovr_s | echo_gate;
    wire transmit_key_gate = key_merge_gate & ~blk_s;

    // permissive overreach trip, held off by transient blocking
    wire pilot_trip = ovr_s & rx_s & ~tb_active;
    wire any_trip   = fault_det & (pilot_trip | z1_s)
                      | wi_trip;

    // phase selection
    wire sel_one = (psel_s == 3'b001) | (psel_s == 3'b010) | (psel_s == 3'b100);
    wire uv_one  = (uv_s == 3'b001) | (uv_s == 3'b010) | (uv_s == 3'b100);
    reg  [2:0] trip_nxt;

    always @* begin
        trip_nxt = 3'b000;
        if (any_trip) begin
            if (!spt_en || open_pole_flag_r || multi_s) begin
                trip_nxt = 3'b111;
            end else if (sel_one) begin
                trip_nxt = psel_s;
            end else if (wi_trip && hybrid && psel_s == 3'b000 && uv_one) begin
                trip_nxt = uv_s;
            end else begin
                trip_nxt = 3'b111;
            end
        end
    end

    wire single_nxt = (trip_nxt == 3'b001) | (trip_nxt == 3'b010)
                      | (trip_nxt == 3'b100);
    wire three_nxt  = (trip_nxt == 3'b111);

    // pole status
    wire any_open = |pole_s;
    wire all_open = &pole_s;
    wire one_open = (pole_s == 3'b001) | (pole_s == 3'b010) | (pole_s == 3'b100);

    // phase held by the single-phase-trip flag: a=0 b=1 c=2
    reg [2:0] spt_phase_r;

    always @(posedge clock) begin
        if (rst) begin
            tx_key_r                  <= 1'b0;
            trip_r                    <= 3'b000;
            weak_infeed_trip_r        <= 1'b0;
            echo_gate_r               <= 1'b0;
            transient_block_r         <= 1'b0;
            reclose_initiate_single_r <= 1'b0;
            reclose_initiate_three_r  <= 1'b0;
            pole_any_open_r           <= 1'b0;
            pole_one_open_r           <= 1'b0;
            pole_all_open_r           <= 1'b0;
            single_phase_trip_flag_r  <= 1'b0;
            open_pole_flag_r          <= 1'b0;
            spt_phase_r               <= 3'b000;
        end else begin
            tx_key_r           <= transmit_key_gate;
            trip_r             <= trip_nxt;
            weak_infeed_trip_r <= wi_trip;
            echo_gate_r        <= echo_gate;
            transient_block_r  <= tb_active;
            reclose_initiate_single_r <= single_nxt & ~cancel_s;
            reclose_initiate_three_r  <= three_nxt & ~cancel_s;
            pole_any_open_r    <= any_open;
            pole_one_open_r    <= one_open;
            pole_all_open_r    <= all_open;
            // set wins over the clear when the poles have just closed
            if (single_nxt) begin
                single_phase_trip_flag_r <= 1'b1;
                spt_phase_r              <= trip_nxt;
            end else if (!any_open && !any_trip) begin
                single_phase_trip_flag_r <= 1'b0;
                spt_phase_r              <= 3'b000;
            end
            if (one_open) begin
                open_pole_flag_r <= 1'b1;
            end else if (!any_open) begin
                open_pole_flag_r <= 1'b0;
            end
        end
    end

    // element masks; pairs are ab=0 bc=1 ca=2
    always @(posedge clock) begin
        if (rst) begin
            phase_pair_enable_r         <= 3'b111;
            ground_dist_enable_r        <= 3'b111;
            fd_magnitude_enable_r       <= 1'b1;
            ground_directional_enable_r <= 1'b1;
            ground_inst_backup_enable_r <= 1'b1;
            ground_time_backup_enable_r <= 1'b1;
        end else begin
            if (single_phase_trip_flag_r) begin
                phase_pair_enable_r[0] <= ~(spt_phase_r[0] | spt_phase_r[1]);
                phase_pair_enable_r[1] <= ~(spt_phase_r[1] | spt_phase_r[2]);
                phase_pair_enable_r[2] <= ~(spt_phase_r[2] | spt_phase_r[0]);
                ground_dist_enable_r   <= ~spt_phase_r;
            end else begin
                phase_pair_enable_r  <= 3'b111;
                ground_dist_enable_r <= 3'b111;
            end
            fd_magnitude_enable_r       <= ~open_pole_flag_r;
            ground_directional_enable_r <= ~open_pole_flag_r;
            ground_inst_backup_enable_r <= ~open_pole_flag_r;
            ground_time_backup_enable_r <= ~open_pole_flag_r;
        end
    end
endmodule

// *** hybrid_trip_props.sv ***
// checker for hybrid_trip_logic: echo, trip, reclose and pole relations
// assumes a pin change reaches the registered outputs three edges later
`timescale 1ns/1ps
module hybrid_trip_props #(
    parameter MS_CYCLES = 4
) (
    input wire       clock,
    input wire       rst,
    input wire       rx_trip,
    input wire       blocking_op,
    input wire       fd_magnitude,
    input wire       fd_change,
    input wire [2:0] pole_open,
    input wire       reclose_cancel,
    input wire       tx_key_r,
    input wire [2:0] trip_r,
    input wire       echo_gate_r,
    input wire       reclose_initiate_single_r,
    input wire       reclose_initiate_three_r,
    input wire       pole_any_open_r,
    input wire       pole_one_open_r,
    input wire       pole_all_open_r,
    input wire       open_pole_flag_r
);
    reg  [2:0]  live_cnt_r;
    reg  [15:0] echo_cnt_r;
    wire        live = live_cnt_r == 3'h4;
    // $past looks three edges back, so wait until that is all after reset
    always @(posedge clock) begin
        live_cnt_r <= rst ? 3'h0 : (live ? live_cnt_r : live_cnt_r + 3'h1);
        echo_cnt_r <= (rst || !echo_gate_r) ? 16'h0 : echo_cnt_r + 16'h1;
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    echo_start_a: assert property (
        $rose(echo_gate_r) && live |-> $past(rx_trip, 3) && !$past(blocking_op, 3))
        else $error("echo gate rose without a clean trip receipt");
    echo_max_a: assert property (
        echo_cnt_r <= 81 * MS_CYCLES + 4)
        else $error("echo gate outlived its window");
    echo_key_a: assert property (
        echo_gate_r && live && !$past(blocking_op, 3) |-> tx_key_r)
        else $error("echo gate without transmitter key");
    trip_fd_a: assert property (
        trip_r != 3'h0 && live |-> $past(fd_change, 3) || $past(fd_magnitude, 3))
        else $error("trip without fault detector");
    ri_cancel_a: assert property (
        live && $past(reclose_cancel, 3) |-> !reclose_initiate_single_r && !reclose_initiate_three_r)
        else $error("reclose initiate while cancelled");
    ri_kind_a: assert property (
        live && !$past(reclose_cancel, 3) |-> reclose_initiate_single_r == $onehot(trip_r)
            && reclose_initiate_three_r == (trip_r == 3'h7))
        else $error("reclose initiate does not match trip");
    pole_state_a: assert property (
        live |-> pole_all_open_r == ($past(pole_open, 3) == 3'h7)
            && pole_one_open_r == $onehot($past(pole_open, 3))
            && pole_any_open_r == ($past(pole_open, 3) != 3'h0))
        else $error("pole indications wrong");
    open_three_a: assert property (
        open_pole_flag_r && $past(open_pole_flag_r) && trip_r != 3'h0 |-> trip_r == 3'h7)
        else $error("open pole trip not three phase");
endmodule
bind hybrid_trip_logic hybrid_trip_props #(.MS_CYCLES(MS_CYCLES)) i_hybrid_trip_props (
    .clock(clock), .rst(rst), .rx_trip(rx_trip), .blocking_op(blocking_op),
    .fd_magnitude(fd_magnitude), .fd_change(fd_change), .pole_open(pole_open),
    .reclose_cancel(reclose_cancel), .tx_key_r(tx_key_r), .trip_r(trip_r),
    .echo_gate_r(echo_gate_r), .reclose_initiate_single_r(reclose_initiate_single_r),
    .reclose_initiate_three_r(reclose_initiate_three_r), .pole_any_open_r(pole_any_open_r),
    .pole_one_open_r(pole_one_open_r), .pole_all_open_r(pole_all_open_r),
    .open_pole_flag_r(open_pole_flag_r));

// *** remote_terminal_model.sv ***
// far-end terminal: keys trip frequency toward us and counts our echoes
// assumes tx_key is our transmitter key on the same clock
`timescale 1ns/1ps
module remote_terminal_model (
    input  wire    clock,
    input  wire    rst,
    input  wire    send_trip,
    input  wire    slow,
    input  wire    tx_key,
    output reg     rx_trip,
    output integer echo_count
);
    reg [3:0] lag_r;
    reg       key_r;
    // slow mode stands for a channel with a longer guard-to-trip shift
    always @(posedge clock) begin
        lag_r <= {lag_r[2:0], send_trip};
        rx_trip <= rst ? 1'b0 : (slow ? lag_r[3] : send_trip);
        key_r <= tx_key;
        echo_count <= rst ? 0 : echo_count + (tx_key && !key_r);
    end
endmodule

// *** hybrid_trip_logic_tb.sv ***
// self-checking bench for hybrid_trip_logic with a far-end terminal model
// assumes one 125 MHz clock; MS_CYCLES shrunk so 1 ms is 4 cycles
`timescale 1ns/1ps
`include "hybrid_trip_map.vh"
module hybrid_trip_logic_tb;
    localparam MS = 4;
    reg         clock, rst, wr, rd, blocking_op, overreach_op, zone1_op, fd_magnitude;
    reg         fd_change, v1_ok, multiphase, reclose_cancel, send_trip, slow;
    reg  [3:0]  addr;
    reg  [31:0] wdata;
    reg  [2:0]  phase_sel, undervoltage, pole_open;
    wire [31:0] rdata_r, echo_count;
    wire [2:0]  trip_r, pairs, gdist;
    wire        rx_trip, tx_key_r, wi_trip, echo_gate_r, tblock, ri1, ri3;
    wire        p_any, p_one, p_all, spt, opf, en_fdm, en_gd, en_gi, en_gt;
    wire [2:0]  watch = {wi_trip, tblock, echo_gate_r};
    integer     bad_count, check_count, t, k, i, ph, path, cancel, e0, win;
    hybrid_trip_logic #(.MS_CYCLES(MS)) i_hybrid_trip_logic (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .rx_trip(rx_trip), .blocking_op(blocking_op),
        .overreach_op(overreach_op), .zone1_op(zone1_op), .fd_magnitude(fd_magnitude),
        .fd_change(fd_change), .v1_ok(v1_ok), .phase_sel(phase_sel), .multiphase(multiphase),
        .undervoltage(undervoltage), .pole_open(pole_open), .reclose_cancel(reclose_cancel),
        .tx_key_r(tx_key_r), .trip_r(trip_r), .weak_infeed_trip_r(wi_trip),
        .echo_gate_r(echo_gate_r), .transient_block_r(tblock),
        .reclose_initiate_single_r(ri1), .reclose_initiate_three_r(ri3),
        .pole_any_open_r(p_any), .pole_one_open_r(p_one), .pole_all_open_r(p_all),
        .single_phase_trip_flag_r(spt), .open_pole_flag_r(opf),
        .phase_pair_enable_r(pairs), .ground_dist_enable_r(gdist),
        .fd_magnitude_enable_r(en_fdm), .ground_directional_enable_r(en_gd),
        .ground_inst_backup_enable_r(en_gi), .ground_time_backup_enable_r(en_gt));
    remote_terminal_model i_remote_terminal_model (
        .clock(clock), .rst(rst), .send_trip(send_trip), .slow(slow), .tx_key(tx_key_r),
        .rx_trip(rx_trip), .echo_count(echo_count));
    task chk(input [31:0] seen, input [31:0] exp_v, input [8*8-1:0] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp_v) begin
                bad_count = bad_count + 1;
                $display("BAD %0s expected %0h seen %0h", what, exp_v, seen);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task reg_wr(input [3:0] a, input [31:0] v);
        begin
            @(posedge clock);
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
        end
    endtask
    task reg_rd(input [3:0] a, input [31:0] v);
        begin
            @(posedge clock);
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            #1 chk(rdata_r, v, "reg");
        end
    endtask
    // bounded wait for watch[b] to reach lvl; t returns the cycles spent
    task wait_lvl(input integer b, input lvl, input integer lim, output integer n);
        begin
            n = 0;
            while (watch[b] !== lvl && n < lim) begin
                @(posedge clock);
                #1 n = n + 1;
            end
            if (watch[b] !== lvl) begin
                chk(b, 32'hFF, "wait");
                give_verdict;
            end
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {wr, rd, blocking_op, overreach_op, zone1_op, fd_magnitude, fd_change} = 7'h0;
        {multiphase, reclose_cancel, send_trip, slow} = 4'h0;
        {addr, wdata, phase_sel, undervoltage, pole_open} = 45'h0;
        v1_ok = 1'b1;
        rst = 1'b1;
        bad_count = 0;
        check_count = 0;
        e0 = $urandom(75);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        reg_rd(`REG_CTRL, {24'h0, `CTRL_RST});
        reg_rd(`REG_WI_DELAY, {24'h0, `WI_DELAY_RST});
        reg_wr(`REG_STATUS, 32'hFFFFFFFF);
        reg_rd(4'hC, 32'h0);
        reg_rd(`REG_STATUS, 32'h0001F800);
        for (k = 0; k < 2; k = k + 1) begin
            reg_wr(`REG_CTRL, k ? 32'h27 : 32'h17);
            win = k ? 50 : 80;
            e0 = echo_count;
            @(posedge clock);
            send_trip <= 1'b1;
            slow <= k;
            wait_lvl(0, 1'b1, 16, t);
            chk(tx_key_r, 1, "txkey");
            wait_lvl(0, 1'b0, 90 * MS, t);
            chk(t >= win * MS - 2 && t <= (win + 1) * MS + 2, 1, "echo");
            chk(echo_count - e0, 1, "echoes");
            @(posedge clock);
            send_trip <= 1'b0;
            blocking_op <= 1'b1;
            wait_lvl(1, 1'b1, 8, t);
            @(posedge clock);
            send_trip <= 1'b1;
            ticks(12);
            chk(echo_gate_r, 0, "eblk");
            @(posedge clock);
            send_trip <= 1'b0;
            blocking_op <= 1'b0;
            win = k ? 60 : 30;
            wait_lvl(1, 1'b0, 70 * MS, t);
            chk(t >= win * MS && t <= (win + 1) * MS + 5, 1, "tblk");
        end
        reg_wr(`REG_WI_DELAY, 32'h5);
        reg_rd(`REG_WI_DELAY, 32'h5);
        @(posedge clock);
        slow <= 1'b0;
        v1_ok <= 1'b0;
        fd_change <= 1'b1;
        undervoltage <= 3'h2;
        ticks(8 * MS);
        chk(wi_trip, 0, "wi_norx");
        @(posedge clock);
        send_trip <= 1'b1;
        wait_lvl(2, 1'b1, 10 * MS, t);
        chk(t >= 5 * MS && t <= 6 * MS + 4, 1, "widly");
        chk({trip_r, ri1}, 4'h5, "wiph");
        wait_lvl(2, 1'b0, 50 * MS, t);
        @(posedge clock);
        {send_trip, fd_change, v1_ok, undervoltage} <= 6'h8;
        ticks(10);
        for (i = 0; i < 12; i = i + 1) begin
            ph = $urandom % 4;
            path = $urandom % 2;
            cancel = $urandom % 2;
            @(posedge clock);
            phase_sel <= (ph == 3) ? 3'h0 : 3'h1 << ph;
            multiphase <= ph == 3;
            {zone1_op, overreach_op, send_trip} <= path ? 3'h3 : 3'h4;
            fd_magnitude <= 1'b1;
            reclose_cancel <= cancel;
            ticks(6);
            chk(trip_r, (ph == 3) ? 7 : 1 << ph, "trip");
            chk(spt, ph != 3, "spt");
            chk({ri1, ri3}, cancel ? 0 : ((ph == 3) ? 1 : 2), "ri");
            @(posedge clock);
            {zone1_op, overreach_op, send_trip, fd_magnitude, multiphase} <= 5'h0;
            phase_sel <= 3'h0;
            ticks(10);
        end
        // plain permissive overreach, single-phase tripping off
        reg_wr(`REG_CTRL, 32'h12);
        @(posedge clock);
        {zone1_op, overreach_op, send_trip, fd_magnitude, reclose_cancel} <= 5'h0E;
        phase_sel <= 3'h1;
        ticks(6);
        chk(echo_gate_r, 0, "pottecho");
        chk({trip_r, ri3}, 4'hF, "potttrip");
        @(posedge clock);
        {zone1_op, overreach_op, send_trip, fd_magnitude, phase_sel} <= 7'h00;
        reg_wr(`REG_CTRL, 32'h17);
        ticks(10);
        @(posedge clock);
        {reclose_cancel, zone1_op, fd_magnitude, phase_sel} <= 6'h19;
        ticks(6);
        @(posedge clock);
        {zone1_op, fd_magnitude, phase_sel, pole_open} <= 8'h01;
        ticks(8);
        chk({p_any, p_one, p_all, opf, spt}, 5'h1B, "pole1");
        chk({pairs, gdist}, 6'h16, "masks");
        chk({en_fdm, en_gd, en_gi, en_gt}, 4'h0, "endis");
        @(posedge clock);
        {zone1_op, fd_magnitude, phase_sel} <= 5'h1A;
        ticks(6);
        chk(trip_r, 0, "magtr");
        @(posedge clock);
        fd_change <= 1'b1;
        ticks(6);
        chk({trip_r, ri3}, 4'hF, "optrip");
        @(posedge clock);
        {zone1_op, fd_magnitude, fd_change, phase_sel, pole_open} <= 9'h7;
        ticks(8);
        chk({p_any, p_one, p_all}, 3'h5, "pole3");
        @(posedge clock);
        pole_open <= 3'h0;
        ticks(8);
        chk({opf, pairs, en_fdm, en_gd, en_gi, en_gt}, 8'h7F, "closed");
        give_verdict;
    end
endmodule
